/* File: hw/ebu_defs.svh */
// constants of the external bus unit: codes, field positions, timing counts
// assumes inclusion by the package and the design modules, by bare name
`ifndef EBU_DEFS_SVH
`define EBU_DEFS_SVH

`define EBU_WINDOWS       4
`define EBU_CS_LINES      5
`define EBU_ADDR_W        24
`define EBU_DATA_W        16
`define EBU_SEL_W         12
`define EBU_SYNC_W        19
// bus mode field: bit 0 multiplexed, bit 1 sixteen-bit data
`define EBU_MODE_MUX_BIT  0
`define EBU_MODE_W16_BIT  1
// address space codes and the upper address lines each one drives
`define EBU_SPACE_64K     2'h0
`define EBU_SPACE_256K    2'h1
`define EBU_SPACE_1M      2'h2
`define EBU_SPACE_16M     2'h3
`define EBU_P4_LINES_64K  8'h00
`define EBU_P4_LINES_256K 8'h03
`define EBU_P4_LINES_1M   8'h0f
`define EBU_P4_LINES_16M  8'hff
// upper address byte position
`define EBU_UPPER_LSB     16
`define EBU_SEL_LSB       12
// timing counts in sys_clk ticks
`define EBU_CNT_ZERO      4'h0
`define EBU_CNT_ONE       4'h1
`define EBU_CS_DEFAULT    5'h01

`endif

/* File: hw/ebu_pkg.sv */
// types of the external bus unit: configuration records and states
// assumes ebu_defs.svh on the include path
`include "ebu_defs.svh"

package ebu_pkg;

    // one bus configuration register
    typedef struct packed {
        logic       bus_act;      // window enabled; no effect in the default register
        logic [1:0] bus_mode;     // data width and multiplexing
        logic [3:0] wait_cnt;     // memory cycle wait ticks
        logic       tristate;     // extra turnaround tick after cycle
        logic       ale_long;     // address strobe one tick longer
        logic       rw_delay;     // read/write strobe delayed one tick
        logic       rdy_en;       // ready handshake used
        logic       rdy_pol;      // active level of ready input
    } ebu_bus_cfg_t;

    // one window select register: base and size of the window
    typedef struct packed {
        logic [`EBU_SEL_W-1:0] base;  // compared with addr[23:12]
        logic [3:0]            size;  // low base bits ignored
    } ebu_win_sel_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_DELAY  = 3'b010,
        ST_STROBE = 3'b011,
        ST_TRI    = 3'b100,
        ST_HELD   = 3'b101
    } ebu_state_t;

endpackage : ebu_pkg

/* File: hw/ebu_window_decode.sv */
// address window decoder of the external bus unit
// assumes stable configuration while a request address is presented
`timescale 1ns/100ps
`include "ebu_defs.svh"

module ebu_window_decode (
    input  wire logic [`EBU_ADDR_W-1:0]              addr,
    input  wire ebu_pkg::ebu_win_sel_t [`EBU_WINDOWS-1:0] win_sel,
    input  wire ebu_pkg::ebu_bus_cfg_t [`EBU_WINDOWS:0]   bus_cfg,
    output ebu_pkg::ebu_bus_cfg_t                    cfg,
    output logic [`EBU_CS_LINES-1:0]                 cs_sel
);

    logic [`EBU_WINDOWS-1:0] hit;

    // per window compare of the upper address bits under the size mask
    genvar gi;
    generate
        for (gi = 0; gi < `EBU_WINDOWS; gi++)
        begin : g_win
            logic [`EBU_SEL_W-1:0] mask;
            assign mask = {`EBU_SEL_W{1'b1}} << win_sel[gi].size;
            assign hit[gi] = bus_cfg[gi+1].bus_act
                & ((addr[`EBU_ADDR_W-1:`EBU_SEL_LSB] & mask)
                   == (win_sel[gi].base & mask));
        end
    endgenerate

    // higher window wins an overlap, default range when nothing hits
    always_comb
    begin
        cfg    = bus_cfg[0];
        cs_sel = `EBU_CS_DEFAULT;
        for (int i = 0; i < `EBU_WINDOWS; i++)
        begin
            if (hit[i])
            begin
                cfg    = bus_cfg[i+1];
                cs_sel = `EBU_CS_LINES'(`EBU_CS_DEFAULT << (i + 1));
            end
        end
    end

endmodule : ebu_window_decode

/* File: hw/ebu_core.sv */
// What this block does
// - single chip mode, or 8/16-bit data, multiplexed or not, 16 to 24 address bits.
// - demultiplexed: address on second port, data on first port or its low byte.
// - multiplexed: first port carries address, then the data of the same cycle.
// - cycle wait, turnaround, address strobe length and strobe delay are programmable.
// - four windows, each a select register paired with a bus configuration register.
// - overlapping windows: four overrides three, two overrides one.
// - addresses outside all windows use the default bus configuration.
// - up to five active-low chip selects, four windows plus default.
// - per window polarity bit chooses the active level of ready.
// - with ready enabled, a cycle ends only once ready reaches its active level.
// - arbitration enable hands request, acknowledge and hold pins to this unit.
// - after reset the unit is arbitration master; acknowledge pin is output.
// - direction bit one selects slave mode; acknowledge pin becomes input.
// - address space restrictable to 1M, 256K, 64K or full 16M.
// - port 4 drives eight, four, two or no upper address lines.
// - by default chip selects change half a cpu clock after address strobe rises.
// - with timing bit set, chip selects change with the address strobe rise.
//
// top of the external bus unit: cpu request port, configuration ports, pins
// assumes sys_clk is twice the cpu clock, so one tick is half a cpu clock
`timescale 1ns/100ps
`include "ebu_defs.svh"

module ebu_core (
    input  wire logic                                 sys_clk,
    input  wire logic                                 resetn,
    input  wire logic                                 clk_en,
    // configuration
    input  wire logic                                 single_chip_mode,
    input  wire ebu_pkg::ebu_win_sel_t [`EBU_WINDOWS-1:0] window_select_reg,
    input  wire ebu_pkg::ebu_bus_cfg_t [`EBU_WINDOWS:0]   bus_config_reg,
    input  wire logic [1:0]                           addr_space,
    input  wire logic                                 chip_select_timing_bit,
    input  wire logic                                 arbitration_enable_bit,
    input  wire logic                                 port6_pin7_direction_bit,
    // cpu request
    input  wire logic                                 req_valid,
    input  wire logic                                 req_write,
    input  wire logic [`EBU_ADDR_W-1:0]               req_addr,
    input  wire logic [`EBU_DATA_W-1:0]               req_wdata,
    output logic                                      req_ready,
    output logic                                      req_done,
    output logic [`EBU_DATA_W-1:0]                    req_rdata,
    // pins
    input  wire logic [`EBU_DATA_W-1:0]               first_parallel_port_in,
    output logic [`EBU_DATA_W-1:0]                    first_parallel_port_out,
    output logic [1:0]                                first_parallel_port_oe,
    output logic [`EBU_DATA_W-1:0]                    second_parallel_port_out,
    output logic                                      second_parallel_port_oe,
    output logic [7:0]                                port4_addr_out,
    output logic [7:0]                                port4_addr_oe,
    output logic                                      ale,
    output logic                                      rd_n,
    output logic                                      wr_n,
    output logic [`EBU_CS_LINES-1:0]                  chip_select_lines_n,
    output logic                                      ctl_oe,
    input  wire logic                                 ready_pin,
    input  wire logic                                 hold_n,
    output logic                                      bus_request_pin_n,
    output logic                                      bus_request_pin_oe,
    input  wire logic                                 grant_acknowledge_pin_n_in,
    output logic                                      grant_acknowledge_pin_n_out,
    output logic                                      grant_acknowledge_pin_oe
);
    ebu_pkg::ebu_state_t     state_reg, state_next;
    ebu_pkg::ebu_bus_cfg_t   cfg_reg, cfg_next, dec_cfg;
    logic [`EBU_CS_LINES-1:0] dec_cs, cs_sel_reg, cs_sel_next;
    logic [`EBU_DATA_W-1:0]  wdata_reg, wdata_next;
    logic                    write_reg, write_next;
    logic [3:0]              cnt_reg, cnt_next;
    logic [`EBU_SYNC_W-1:0]  sync1_reg, sync2_reg;
    logic                    ready_reg, ready_next, done_reg, done_next;
    logic [`EBU_DATA_W-1:0]  rdata_reg, rdata_next;
    logic [`EBU_DATA_W-1:0]  p0_reg, p0_next, p1_reg, p1_next;
    logic [1:0]              p0_oe_reg, p0_oe_next;
    logic                    p1_oe_reg, p1_oe_next;
    logic [7:0]              p4_reg, p4_next, p4_oe_reg, p4_oe_next;
    logic                    ale_reg, ale_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
    logic [`EBU_CS_LINES-1:0] cs_n_reg, cs_n_next;
    logic                    ctl_oe_reg, ctl_oe_next;
    logic                    rq_n_reg, rq_n_next, rq_oe_reg, rq_oe_next;
    logic                    ack_reg, ack_next, ack_oe_reg, ack_oe_next;
    logic [`EBU_DATA_W-1:0]  data_sync;
    logic                    ready_sync, hold_req, granted, slave, owned, can_start;
    logic                    wide;
    logic [7:0]              p4_lines;
    ebu_window_decode u_decode (
        .addr    (req_addr),
        .win_sel (window_select_reg),
        .bus_cfg (bus_config_reg),
        .cfg     (dec_cfg),
        .cs_sel  (dec_cs)
    );
    // two flops on every pin input; only the second stage is read
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (clk_en)
        begin
            sync1_reg <= {grant_acknowledge_pin_n_in, hold_n, ready_pin,
                          first_parallel_port_in};
            sync2_reg <= sync1_reg;
        end
    end

    // reset zeros the syncs, so hold and grant read asserted until pins arrive
    assign data_sync  = sync2_reg[`EBU_DATA_W-1:0];
    assign ready_sync = sync2_reg[`EBU_DATA_W];
    assign slave      = arbitration_enable_bit & port6_pin7_direction_bit;
    assign hold_req   = arbitration_enable_bit & ~slave & ~sync2_reg[`EBU_DATA_W+1];
    assign granted    = ~sync2_reg[`EBU_DATA_W+2];
    assign owned      = slave ? granted : 1'b1;
    assign can_start  = ~single_chip_mode & owned & ~hold_req;
    assign wide       = cfg_reg.bus_mode[`EBU_MODE_W16_BIT];
    // upper address lines per address space
    always_comb
    begin
        case (addr_space)
            `EBU_SPACE_64K:  p4_lines = `EBU_P4_LINES_64K;
            `EBU_SPACE_256K: p4_lines = `EBU_P4_LINES_256K;
            `EBU_SPACE_1M:   p4_lines = `EBU_P4_LINES_1M;
            default:         p4_lines = `EBU_P4_LINES_16M;
        endcase
    end

    // bus cycle sequencer and pin values
    always_comb
    begin
        state_next   = state_reg;
        cfg_next     = cfg_reg;
        cs_sel_next  = cs_sel_reg;
        wdata_next   = wdata_reg;
        write_next   = write_reg;
        cnt_next     = cnt_reg;
        done_next    = 1'b0;
        rdata_next   = rdata_reg;
        p0_next      = p0_reg;
        p0_oe_next   = p0_oe_reg;
        p1_next      = p1_reg;
        p1_oe_next   = p1_oe_reg;
        p4_next      = p4_reg;
        p4_oe_next   = p4_oe_reg;
        ale_next     = ale_reg;
        rd_n_next    = rd_n_reg;
        wr_n_next    = wr_n_reg;
        cs_n_next    = cs_n_reg;
        ctl_oe_next  = ctl_oe_reg;
        rq_n_next    = rq_n_reg;
        ack_next     = ack_reg;
        // acknowledge pin drives only as master under arbitration
        ack_oe_next  = arbitration_enable_bit & ~slave;
        rq_oe_next   = arbitration_enable_bit;
        case (state_reg)
            ebu_pkg::ST_IDLE:
            begin
                ale_next    = 1'b0;
                rd_n_next   = 1'b1;
                wr_n_next   = 1'b1;
                cs_n_next   = '1;
                p0_oe_next  = 2'b00;
                p1_oe_next  = 1'b0;
                ctl_oe_next = owned & ~single_chip_mode;
                p4_oe_next  = (owned & ~single_chip_mode) ? p4_lines : 8'h00;
                rq_n_next = ~(slave & req_valid);
                if (req_valid && ready_reg)
                begin
                    state_next  = ebu_pkg::ST_ADDR;
                    cfg_next    = dec_cfg;
                    cs_sel_next = dec_cs;
                    wdata_next  = req_wdata;
                    write_next  = req_write;
                    cnt_next    = dec_cfg.ale_long ? `EBU_CNT_ONE : `EBU_CNT_ZERO;
                    ale_next    = 1'b1;
                    p4_next     = req_addr[`EBU_ADDR_W-1:`EBU_UPPER_LSB];
                    p4_oe_next  = p4_lines;
                    p0_next     = req_addr[`EBU_DATA_W-1:0];
                    p1_next     = req_addr[`EBU_DATA_W-1:0];
                    p0_oe_next  = {2{dec_cfg.bus_mode[`EBU_MODE_MUX_BIT]}};
                    p1_oe_next  = ~dec_cfg.bus_mode[`EBU_MODE_MUX_BIT];
                    if (chip_select_timing_bit)
                        cs_n_next = ~dec_cs;
                end
                else if (hold_req)
                begin
                    // float first; acknowledge follows one tick later
                    state_next  = ebu_pkg::ST_HELD;
                    ctl_oe_next = 1'b0;
                    p4_oe_next  = 8'h00;
                end
            end
            ebu_pkg::ST_ADDR:
            begin
                if (cs_n_reg == '1)
                    cs_n_next = ~cs_sel_reg;
                if (cnt_reg == `EBU_CNT_ZERO)
                begin
                    ale_next = 1'b0;
                    // data phase on first port; a multiplexed address leaves it here
                    p0_next    = wdata_reg;
                    p0_oe_next = write_reg ? {wide, 1'b1} : 2'b00;
                    state_next = cfg_reg.rw_delay ? ebu_pkg::ST_DELAY : ebu_pkg::ST_STROBE;
                end
                else
                    cnt_next = cnt_reg - `EBU_CNT_ONE;
            end
            ebu_pkg::ST_DELAY:
                state_next = ebu_pkg::ST_STROBE;
            ebu_pkg::ST_STROBE:
            begin
                if (cnt_reg != `EBU_CNT_ZERO)
                    cnt_next = cnt_reg - `EBU_CNT_ONE;
                else if (!cfg_reg.rdy_en || ready_sync == cfg_reg.rdy_pol)
                begin
                    rd_n_next  = 1'b1;
                    wr_n_next  = 1'b1;
                    cs_n_next  = '1;
                    p0_oe_next = 2'b00;
                    p1_oe_next = 1'b0;
                    done_next  = 1'b1;
                    if (!write_reg)
                        rdata_next = wide ? data_sync : {8'h00, data_sync[7:0]};
                    state_next = cfg_reg.tristate ? ebu_pkg::ST_TRI : ebu_pkg::ST_IDLE;
                end
            end
            ebu_pkg::ST_TRI:
                state_next = ebu_pkg::ST_IDLE;
            ebu_pkg::ST_HELD:
            begin
                ack_next  = ~hold_req;
                // ask the other master back while work waits
                rq_n_next = ~req_valid;
                if (!hold_req)
                    state_next = ebu_pkg::ST_IDLE;
            end
            default:
                state_next = ebu_pkg::ST_IDLE;
        endcase
        // strobe opens on entry, whichever state leads into it
        if (state_next == ebu_pkg::ST_STROBE && state_reg != ebu_pkg::ST_STROBE)
        begin
            rd_n_next = write_reg;
            wr_n_next = ~write_reg;
            cnt_next  = cfg_reg.wait_cnt;
        end
        ready_next = (state_next == ebu_pkg::ST_IDLE) & can_start & ~done_next
                     & ~(state_reg == ebu_pkg::ST_IDLE & req_valid & ready_reg);
    end

    // register stage; clk_en low freezes everything
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_reg  <= ebu_pkg::ST_IDLE;
            cfg_reg    <= '0;
            cnt_reg    <= `EBU_CNT_ZERO;
            ready_reg  <= 1'b0;
            done_reg   <= 1'b0;
            rdata_reg  <= '0;
            p0_reg     <= '0;
            p0_oe_reg  <= 2'b00;
            p1_reg     <= '0;
            p1_oe_reg  <= 1'b0;
            p4_reg     <= 8'h00;
            p4_oe_reg  <= 8'h00;
            ale_reg    <= 1'b0;
            rd_n_reg   <= 1'b1;
            wr_n_reg   <= 1'b1;
            cs_n_reg   <= '1;
            ctl_oe_reg <= 1'b0;
            rq_n_reg   <= 1'b1;
            rq_oe_reg  <= 1'b0;
            ack_reg    <= 1'b1;
            ack_oe_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg  <= state_next;
            cfg_reg    <= cfg_next;
            cs_sel_reg <= cs_sel_next;
            wdata_reg  <= wdata_next;
            write_reg  <= write_next;
            cnt_reg    <= cnt_next;
            ready_reg  <= ready_next;
            done_reg   <= done_next;
            rdata_reg  <= rdata_next;
            p0_reg     <= p0_next;
            p0_oe_reg  <= p0_oe_next;
            p1_reg     <= p1_next;
            p1_oe_reg  <= p1_oe_next;
            p4_reg     <= p4_next;
            p4_oe_reg  <= p4_oe_next;
            ale_reg    <= ale_next;
            rd_n_reg   <= rd_n_next;
            wr_n_reg   <= wr_n_next;
            cs_n_reg   <= cs_n_next;
            ctl_oe_reg <= ctl_oe_next;
            rq_n_reg   <= rq_n_next;
            rq_oe_reg  <= rq_oe_next;
            ack_reg    <= ack_next;
            ack_oe_reg <= ack_oe_next;
        end
    end

    // every output straight from its flop
    assign req_ready                   = ready_reg;
    assign req_done                    = done_reg;
    assign req_rdata                   = rdata_reg;
    assign first_parallel_port_out     = p0_reg;
    assign first_parallel_port_oe      = p0_oe_reg;
    assign second_parallel_port_out    = p1_reg;
    assign second_parallel_port_oe     = p1_oe_reg;
    assign port4_addr_out              = p4_reg;
    assign port4_addr_oe               = p4_oe_reg;
    assign ale                         = ale_reg;
    assign rd_n                        = rd_n_reg;
    assign wr_n                        = wr_n_reg;
    assign chip_select_lines_n         = cs_n_reg;
    assign ctl_oe                      = ctl_oe_reg;
    assign bus_request_pin_n           = rq_n_reg;
    assign bus_request_pin_oe          = rq_oe_reg;
    assign grant_acknowledge_pin_n_out = ack_reg;
    assign grant_acknowledge_pin_oe    = ack_oe_reg;

endmodule : ebu_core

/* File: dv/ebu_mem_model.sv */
// far-side memory model: answers reads with a pattern, slow ready on demand
// assumes the demultiplexed address bus on addr; lag counts strobe ticks
`timescale 1ns/100ps
module ebu_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        strobe_n,
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  lag,
    output logic      [15:0] data,
    output logic             rdy
);
    logic [3:0] cnt_reg;
    initial data = 16'h0000;
    // data only while strobed; toggles otherwise so a stale value never matches
    always @(posedge sys_clk)
    begin
        cnt_reg <= strobe_n ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hf};
        data    <= strobe_n ? ~data : addr ^ 16'ha5a5;
    end
    assign rdy = !strobe_n && cnt_reg >= lag;
endmodule : ebu_mem_model

/* File: dv/ebu_core_chk.sv */
// assertions on the pins and request port of the external bus unit
// assumes binding to ebu_core, one clock domain, synchronous reset
`timescale 1ns/100ps
module ebu_core_chk (
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    input wire logic                        single_chip_mode,
    input wire ebu_pkg::ebu_bus_cfg_t [4:0] bus_config_reg,
    input wire logic [1:0]                  addr_space,
    input wire logic                        chip_select_timing_bit,
    input wire logic                        arbitration_enable_bit,
    input wire logic                        req_ready,
    input wire logic                        req_done,
    input wire logic [1:0]                  first_parallel_port_oe,
    input wire logic                        second_parallel_port_oe,
    input wire logic [7:0]                  port4_addr_oe,
    input wire logic                        ale,
    input wire logic [4:0]                  chip_select_lines_n,
    input wire logic                        ctl_oe,
    input wire logic                        ready_pin,
    input wire logic                        bus_request_pin_oe,
    input wire logic                        grant_acknowledge_pin_n_out,
    input wire logic                        grant_acknowledge_pin_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ready is synchronised, so five inactive samples must hold the cycle open
    property p_single; single_chip_mode [*2] |-> !req_ready && !ctl_oe; endproperty
    a_single: assert property (p_single) else $error("single chip still drives");
    property p_cs_one; $onehot0(~chip_select_lines_n); endproperty
    a_cs_one: assert property (p_cs_one) else $error("several selects low");
    property p_rdy; (bus_config_reg[0].rdy_en && ready_pin != bus_config_reg[0].rdy_pol) [*5]
        |-> !req_done; endproperty
    a_rdy: assert property (p_rdy) else $error("cycle ended without ready");
    property p_arb; !arbitration_enable_bit [*2] |-> !bus_request_pin_oe; endproperty
    a_arb: assert property (p_arb) else $error("request pin driven");
    property p_space; ale |-> port4_addr_oe == (addr_space == 2'h3 ? 8'hff :
        addr_space == 2'h2 ? 8'h0f : addr_space == 2'h1 ? 8'h03 : 8'h00); endproperty
    a_space: assert property (p_space) else $error("upper lines wrong");
    property p_cs_late; !chip_select_timing_bit && $rose(ale)
        |-> &chip_select_lines_n ##1 !(&chip_select_lines_n); endproperty
    a_cs_late: assert property (p_cs_late) else $error("select not one tick late");
    property p_cs_early; chip_select_timing_bit && $rose(ale) |-> !(&chip_select_lines_n);
    endproperty
    a_cs_early: assert property (p_cs_early) else $error("select not with strobe");
    property p_float; grant_acknowledge_pin_oe && !grant_acknowledge_pin_n_out |-> !ctl_oe
        && !second_parallel_port_oe && first_parallel_port_oe == 2'h0; endproperty
    a_float: assert property (p_float) else $error("bus driven while granted");
endmodule : ebu_core_chk

/* File: dv/ebu_core_bench.sv */
// bench of the external bus unit: cpu requests against a memory model
// assumes reads only in demultiplexed modes, where the model sees the address
`timescale 1ns/100ps
module ebu_core_bench;
    logic sys_clk, resetn, clk_en, single_chip_mode, chip_select_timing_bit, hold_n, ale,
          arbitration_enable_bit, port6_pin7_direction_bit, req_valid, req_write, rd_n,
          req_ready, req_done, second_parallel_port_oe, wr_n, ctl_oe, ready_pin, rdy, pol,
          bus_request_pin_n, bus_request_pin_oe, grant_acknowledge_pin_n_in,
          grant_acknowledge_pin_n_out, grant_acknowledge_pin_oe;
    ebu_pkg::ebu_bus_cfg_t [4:0] bus_config_reg;
    ebu_pkg::ebu_win_sel_t [3:0] window_select_reg;
    logic [1:0]  addr_space, first_parallel_port_oe;
    logic [23:0] req_addr;
    logic [15:0] req_wdata, req_rdata, first_parallel_port_in, first_parallel_port_out,
                 second_parallel_port_out, adr_seen, dat_seen;
    logic [7:0]  port4_addr_out, port4_addr_oe;
    logic [4:0]  chip_select_lines_n, cs_seen;
    logic [3:0]  lag;
    logic [23:0] wadr [5] = '{24'h80_1234, 24'h05_1111, 24'h02_2222, 24'h03_3333, 24'h04_4444};
    int          bad_count = 0, num_checks = 0, lat, tick = 0;
    ebu_core u_dut (.*);
    ebu_mem_model u_mem (.sys_clk(sys_clk), .strobe_n(rd_n & wr_n), .lag(lag),
        .addr(second_parallel_port_out), .data(first_parallel_port_in), .rdy(rdy));
    assign ready_pin = pol ? rdy : !rdy;
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ceiling far past the hundred and forty or so cycles needed
    always @(posedge sys_clk)
    begin
        tick <= tick + 1;
        if (tick == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // same settings for default and all windows; wait ticks 3 for the read syncs
    task cfg_all(input logic [1:0] m, input logic al, input logic rw, input logic re);
        for (int i = 0; i < 5; i++)
            bus_config_reg[i] = {1'b1, m, 4'h3, al, al, rw, re, pol};
    endtask : cfg_all
    // one request; logs latency, selects, address and write data
    task access(input logic wr, input logic [23:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        cs_seen   = 5'h00;
        lat       = 0;
        while (req_ready !== 1'b1 && lat < 50)
        begin
            @(negedge sys_clk);
            lat++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        lat       = 0;
        while (req_done !== 1'b1 && lat < 50)
        begin
            lat++;
            cs_seen = cs_seen | ~chip_select_lines_n;
            if (ale)
                adr_seen = (first_parallel_port_oe != 2'h0) ? first_parallel_port_out :
                    second_parallel_port_out;
            if (!wr_n)
                dat_seen = first_parallel_port_out;
            @(negedge sys_clk);
        end
        chk(adr_seen, a[15:0]);
    endtask : access
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial
    begin
        {clk_en, hold_n, grant_acknowledge_pin_n_in} = 3'h7;
        {single_chip_mode, chip_select_timing_bit, arbitration_enable_bit,
         port6_pin7_direction_bit, req_valid, req_write, pol, resetn} = 8'h00;
        {req_addr, req_wdata, lag, addr_space} = 46'h0;
        window_select_reg = {12'h040, 4'h4, 12'h030, 4'h4, 12'h020, 4'h4, 12'h000, 4'h8};
        cfg_all(2'h2, 1'b0, 1'b0, 1'b0);
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        addr_space = 2'h3;
        for (int i = 0; i < 5; i++)
        begin
            access(1'b0, wadr[i], 16'h0000);
            chk(req_rdata, wadr[i][15:0] ^ 16'ha5a5);
            chk({11'h000, cs_seen}, 16'h0001 << i);
        end
        $display("test windows done");
        for (int k = 0; k < 4; k++)
        begin
            addr_space = 2'(k);
            cfg_all(2'h2, k[0], k[1], 1'b0);
            access(1'b0, 24'h00_9876, 16'h0000);
            chk(req_rdata, 16'h9876 ^ 16'ha5a5);
            chk(16'(lat), 16'(5 + k[0] + k[1]));
        end
        $display("test timing and space done");
        lag = 4'h6;
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            cfg_all(2'h2, 1'b0, 1'b0, 1'b1);
            access(1'b0, 24'h80_00f0, 16'h0000);
            chk(req_rdata, 16'h00f0 ^ 16'ha5a5);
            chk(16'(lat > 6), 16'h0001);
        end
        lag = 4'h0;
        $display("test ready done");
        cfg_all(2'h0, 1'b0, 1'b0, 1'b0);
        access(1'b0, 24'h80_5a3c, 16'h0000);
        chk(req_rdata, {8'h00, 8'h3c ^ 8'ha5});
        cfg_all(2'h3, 1'b0, 1'b0, 1'b0);
        chip_select_timing_bit = 1'b1;
        access(1'b1, 24'h80_beef, 16'h1357);
        chk(dat_seen, 16'h1357);
        chip_select_timing_bit = 1'b0;
        $display("test modes done");
        cfg_all(2'h2, 1'b0, 1'b0, 1'b0);
        arbitration_enable_bit = 1'b1;
        repeat (3) @(negedge sys_clk);
        hold_n = 1'b0;
        lat = 0;
        while (grant_acknowledge_pin_n_out !== 1'b0 && lat < 20)
        begin
            @(negedge sys_clk);
            lat++;
        end
        chk(16'({ctl_oe, req_ready, grant_acknowledge_pin_oe}), 16'h0001);
        hold_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        arbitration_enable_bit = 1'b0;
        access(1'b0, 24'h80_0042, 16'h0000);
        chk(req_rdata, 16'h0042 ^ 16'ha5a5);
        {arbitration_enable_bit, port6_pin7_direction_bit} = 2'h3;
        repeat (3) @(negedge sys_clk);
        chk(16'({bus_request_pin_n, req_ready, grant_acknowledge_pin_oe}), 16'h0004);
        single_chip_mode = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(16'(req_ready), 16'h0000);
        $display("test arbitration and single chip done");
        stop_test();
    end
endmodule : ebu_core_bench
bind ebu_core ebu_core_chk u_chk (.*);
